// file: dcw_params.svh
// Offsets, field positions, reset values and timing counts of the DAC configuration port
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH

`define DCW_NUM_REGS 9
`define DCW_LAST_ADDR 5'h08
`define DCW_PTR_MAX 5'h1F

`define DCW_ADDR_GAIN_MODE 4'h0
`define DCW_ADDR_SINE_GAIN 4'h1
`define DCW_ADDR_SWITCH_SINE_RANGE_BIT 4'h2
`define DCW_ADDR_SINE_RANGE_BIT_DIV 4'h3
`define DCW_ADDR_DC_LOW 4'h4
`define DCW_ADDR_DC_MID 4'h5
`define DCW_ADDR_DC_HIGH 4'h6
`define DCW_ADDR_PULSE_FIRST 4'h7
`define DCW_ADDR_PULSE_SECOND 4'h8

`define DCW_RST_GAIN_MODE 8'h18
`define DCW_RST_SINE_RANGE_BIT_DIV 8'h07
`define DCW_RST_OTHER 8'h00

`define DCW_ID_MSB 7
`define DCW_ID_LSB 5
`define DCW_GAIN_MSB 4
`define DCW_GAIN_LSB 2
`define DCW_MODE_MSB 1
`define DCW_MODE_LSB 0
`define DCW_MASK_GAIN_MODE 8'h1F
`define DCW_MASK_PULSE 8'h1F
`define DCW_MASK_FULL 8'hFF

`define DCW_OP_WRITE 4'h4
`define DCW_OP_RESET 7'h03
`define DCW_MODE_PULSE 2'h3
`define DCW_GAIN_0DB 3'h0
`define DCW_GAIN_12DB 3'h2
`define DCW_GAIN_24DB 3'h4
`define DCW_GAIN_36DB 3'h6

`define DCW_OFF_TX 8'h00
`define DCW_OFF_STATUS 8'h04
`define DCW_TX_LAST_BIT 8

`define DCW_CLK_PERIOD_NS 10
`define DCW_SCLK_PERIOD_NS 160
`define DCW_SCLK_HALF_CYC (`DCW_SCLK_PERIOD_NS / (2 * `DCW_CLK_PERIOD_NS))

`endif

// file: dcw_pkg.sv
// Types shared by both ends of the DAC configuration port
package dcw_pkg;

  typedef enum logic [1:0] {
    DCW_DEV_CMD1 = 2'b00,
    DCW_DEV_CMD2 = 2'b01,
    DCW_DEV_DATA = 2'b10,
    DCW_DEV_SKIP = 2'b11
  } dcw_dev_state_e;

  typedef enum logic [1:0] {
    DCW_HOST_IDLE = 2'b00,
    DCW_HOST_LOW = 2'b01,
    DCW_HOST_HIGH = 2'b10,
    DCW_HOST_GAP = 2'b11
  } dcw_host_state_e;

  typedef logic [8:0][7:0] dcw_bank_t;

  typedef struct packed {
    dcw_dev_state_e st;
    logic sclk_prev;
    logic [7:0] shreg;
    logic [2:0] bits;
    logic [4:0] ptr;
    logic [3:0] left;
    dcw_bank_t regs;
    logic gain_ok;
    logic gen_reset;
    logic dout;
    logic dout_oe;
  } dcw_dev_s;

  typedef struct packed {
    dcw_host_state_e st;
    logic [7:0] shreg;
    logic [2:0] bits;
    logic [7:0] cnt;
    logic last;
    logic cs_n;
    logic sclk;
    logic din;
    logic dp_tx;
    logic [31:0] hrdata;
  } dcw_host_s;

endpackage

// file: dcw_if.sv
// Serial configuration link between host controller and DAC register bank
`timescale 1ns/1ps
`default_nettype none
interface dcw_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;

  modport dev (
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input dout,
    input dout_oe
  );
endinterface
`default_nettype wire

// file: dcw_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dcw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dcw_sync_s;

  dcw_sync_s cur;
  dcw_sync_s next_cur;

  // First stage feeds only the second stage
  always_comb begin
    next_cur.meta = d;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= {RESET_VALUE, RESET_VALUE};
    end else begin
      cur <= next_cur;
    end
  end

  assign q = cur.stable;
endmodule
`default_nettype wire

// file: dcw_device.sv
// DAC configuration register bank with serial write and reset command decoder
// What this block does
// - Write is two command bytes then data
// - First byte: write code, start address
// - Second byte low nibble is count minus one
// - Data bytes MSB first, consecutive registers
// - Address pointer never wraps to zero
// - Reset command restores all register defaults
// - Same defaults at power-up, pin, command
// - Defaults: sine, 31.25 Hz, -36 dB, open
// - Nine 8-bit registers, addresses 0 to 8
// - Register 0 top bits are read-only ID
// - Register 0 bits 4:2 pick analog gain
// - Pulse levels ignore analog and digital gain
// - Reduced variant supports gains 000, 010, 100
// - Host rewrites gain before using reduced variant
// - Register 0 bits 1:0 pick mode
// - Mode change resets the signal generator
// - Sine gain reg 1, dc gain regs 4-6
// - Input sampled on rising serial clock edge
// - Reset command is 06h or 07h, alone
// - Chip select high aborts command, floats output
`include "dcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcw_device #(
  parameter bit REDUCED_RANGE = 1'b0,
  // Arbitrary identification value
  parameter logic [2:0] ID_VALUE = 3'h5
) (
  input wire logic hclk,
  input wire logic hresetn,
  dcw_if.dev link,
  input wire logic reset_powerdown_pin_n,
  output logic [7:0] gain_mode_ctrl,
  output logic [7:0] sine_digital_gain,
  output logic [7:0] switch_frequency_ctrl,
  output logic [7:0] frequency_divisor,
  output logic [23:0] dc_gain,
  output logic [7:0] pulse_level_first,
  output logic [7:0] pulse_level_second,
  output logic [2:0] analog_gain,
  output logic [1:0] mode,
  output logic analog_gain_used,
  output logic gain_supported,
  output logic signal_gen_reset
);

  dcw_pkg::dcw_dev_s cur;
  dcw_pkg::dcw_dev_s next_cur;
  logic [3:0] pins;
  logic s_cs_n;
  logic s_sclk;
  logic s_din;
  logic s_rst_n;

  // All four pins come from outside the clock domain
  dcw_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'hD)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({link.cs_n, reset_powerdown_pin_n, link.sclk, link.din}),
    .q(pins)
  );

  assign s_cs_n = pins[3];
  assign s_rst_n = pins[2];
  assign s_sclk = pins[1];
  assign s_din = pins[0];

  function automatic dcw_pkg::dcw_bank_t default_bank();
    dcw_pkg::dcw_bank_t b;
    for (int i = 0; i < `DCW_NUM_REGS; i++) begin
      b[i] = `DCW_RST_OTHER;
    end
    b[`DCW_ADDR_GAIN_MODE] = `DCW_RST_GAIN_MODE;
    b[`DCW_ADDR_SINE_RANGE_BIT_DIV] = `DCW_RST_SINE_RANGE_BIT_DIV;
    return b;
  endfunction

  // Writable bits per address; ID and fixed-zero bits stay put
  function automatic logic [7:0] write_mask(input logic [4:0] a);
    logic [7:0] m;
    m = `DCW_MASK_FULL;
    if (a == {1'b0, `DCW_ADDR_GAIN_MODE}) begin
      m = `DCW_MASK_GAIN_MODE;
    end else if (a == {1'b0, `DCW_ADDR_PULSE_FIRST} || a == {1'b0, `DCW_ADDR_PULSE_SECOND}) begin
      m = `DCW_MASK_PULSE;
    end
    return m;
  endfunction

  function automatic logic gain_ok_of(input logic [2:0] g);
    logic ok;
    if (REDUCED_RANGE) begin
      ok = (g == `DCW_GAIN_0DB) || (g == `DCW_GAIN_12DB) || (g == `DCW_GAIN_24DB);
    end else begin
      ok = (g <= `DCW_GAIN_36DB);
    end
    return ok;
  endfunction

  always_comb begin
    logic [7:0] rx_byte;
    logic rise;
    logic [7:0] m;
    rx_byte = {cur.shreg[6:0], s_din};
    rise = s_sclk & ~cur.sclk_prev & ~s_cs_n;
    m = write_mask(cur.ptr);
    next_cur = cur;
    next_cur.sclk_prev = s_sclk;
    next_cur.gen_reset = 1'b0;
    // No read command, so the output is never driven
    next_cur.dout = 1'b0;
    next_cur.dout_oe = 1'b0;
    if (s_cs_n) begin
      next_cur.st = dcw_pkg::DCW_DEV_CMD1;
      next_cur.bits = 3'h0;
    end else if (rise) begin
      next_cur.shreg = rx_byte;
      next_cur.bits = cur.bits + 3'h1;
      if (cur.bits == 3'h7) begin
        unique case (cur.st)
          dcw_pkg::DCW_DEV_CMD1: begin
            if (rx_byte[7:4] == `DCW_OP_WRITE) begin
              next_cur.ptr = {1'b0, rx_byte[3:0]};
              next_cur.st = dcw_pkg::DCW_DEV_CMD2;
            end else if (rx_byte[7:1] == `DCW_OP_RESET) begin
              next_cur.regs = default_bank();
            end else begin
              // Read and unknown opcodes: drop the rest of the frame
              next_cur.st = dcw_pkg::DCW_DEV_SKIP;
            end
          end
          dcw_pkg::DCW_DEV_CMD2: begin
            next_cur.left = rx_byte[3:0];
            next_cur.st = dcw_pkg::DCW_DEV_DATA;
          end
          dcw_pkg::DCW_DEV_DATA: begin
            for (int i = 0; i < `DCW_NUM_REGS; i++) begin
              if (cur.ptr == 5'(i)) begin
                next_cur.regs[i] = (rx_byte & m) | (cur.regs[i] & ~m);
              end
            end
            // Addresses above the bank fall through unmatched
            if (cur.ptr > `DCW_LAST_ADDR) begin
              next_cur.regs = cur.regs;
            end
            // Saturating pointer: counts beyond 8 can never alias address 0
            if (cur.ptr != `DCW_PTR_MAX) begin
              next_cur.ptr = cur.ptr + 5'h01;
            end
            if (cur.left == 4'h0) begin
              next_cur.st = dcw_pkg::DCW_DEV_CMD1;
            end else begin
              next_cur.left = cur.left - 4'h1;
            end
          end
          dcw_pkg::DCW_DEV_SKIP: begin
            next_cur.st = dcw_pkg::DCW_DEV_SKIP;
          end
        endcase
      end
    end
    // Pin held low keeps the bank at defaults, so release leaves defaults
    if (!s_rst_n) begin
      next_cur.regs = default_bank();
      next_cur.st = dcw_pkg::DCW_DEV_CMD1;
      next_cur.bits = 3'h0;
    end
    if (next_cur.regs[0][`DCW_MODE_MSB:`DCW_MODE_LSB] != cur.regs[0][`DCW_MODE_MSB:`DCW_MODE_LSB]) begin
      next_cur.gen_reset = 1'b1;
    end
    next_cur.gain_ok = gain_ok_of(next_cur.regs[0][`DCW_GAIN_MSB:`DCW_GAIN_LSB]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur.st <= dcw_pkg::DCW_DEV_CMD1;
      cur.sclk_prev <= 1'b0;
      cur.shreg <= 8'h00;
      cur.bits <= 3'h0;
      cur.ptr <= 5'h00;
      cur.left <= 4'h0;
      cur.regs <= default_bank();
      cur.gain_ok <= !REDUCED_RANGE;
      cur.gen_reset <= 1'b0;
      cur.dout <= 1'b0;
      cur.dout_oe <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign gain_mode_ctrl = {ID_VALUE, cur.regs[0][`DCW_GAIN_MSB:0]};
  assign sine_digital_gain = cur.regs[`DCW_ADDR_SINE_GAIN];
  assign switch_frequency_ctrl = cur.regs[`DCW_ADDR_SWITCH_SINE_RANGE_BIT];
  assign frequency_divisor = cur.regs[`DCW_ADDR_SINE_RANGE_BIT_DIV];
  assign dc_gain = {cur.regs[`DCW_ADDR_DC_HIGH], cur.regs[`DCW_ADDR_DC_MID], cur.regs[`DCW_ADDR_DC_LOW]};
  assign pulse_level_first = cur.regs[`DCW_ADDR_PULSE_FIRST];
  assign pulse_level_second = cur.regs[`DCW_ADDR_PULSE_SECOND];
  assign analog_gain = cur.regs[0][`DCW_GAIN_MSB:`DCW_GAIN_LSB];
  assign mode = cur.regs[0][`DCW_MODE_MSB:`DCW_MODE_LSB];
  // Pulse levels bypass both gain paths
  assign analog_gain_used = (cur.regs[0][`DCW_MODE_MSB:`DCW_MODE_LSB] != `DCW_MODE_PULSE);
  assign gain_supported = cur.gain_ok;
  assign signal_gen_reset = cur.gen_reset;
  assign link.dout = cur.dout;
  assign link.dout_oe = cur.dout_oe;

endmodule
`default_nettype wire

// file: dcw_host.sv
// Serial host controller: AHB-Lite registers drive byte transfers to the DAC
`include "dcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcw_host #(
  parameter int SCLK_HALF = `DCW_SCLK_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  dcw_if.host link
);

  dcw_pkg::dcw_host_s cur;
  dcw_pkg::dcw_host_s next_cur;
  localparam logic [7:0] HALF_RELOAD = 8'(SCLK_HALF - 1);

  always_comb begin
    logic busy;
    busy = (cur.st != dcw_pkg::DCW_HOST_IDLE);
    next_cur = cur;
    next_cur.dp_tx = 1'b0;
    // Address phase; only whole-word transfers are expected, hsize is not checked
    if (hsel && htrans[1] && hready) begin
      next_cur.dp_tx = hwrite && (haddr[7:0] == `DCW_OFF_TX);
      if (!hwrite && haddr[7:0] == `DCW_OFF_STATUS) begin
        next_cur.hrdata = {30'h0, ~cur.cs_n, busy};
      end else begin
        next_cur.hrdata = 32'h0;
      end
    end
    unique case (cur.st)
      dcw_pkg::DCW_HOST_IDLE: begin
        // A write while a byte is in flight is dropped
        if (cur.dp_tx) begin
          next_cur.shreg = hwdata[7:0];
          next_cur.last = hwdata[`DCW_TX_LAST_BIT];
          next_cur.cs_n = 1'b0;
          next_cur.din = hwdata[7];
          next_cur.bits = 3'h0;
          next_cur.cnt = HALF_RELOAD;
          next_cur.st = dcw_pkg::DCW_HOST_LOW;
        end
      end
      dcw_pkg::DCW_HOST_LOW: begin
        if (cur.cnt == 8'h00) begin
          next_cur.sclk = 1'b1;
          next_cur.cnt = HALF_RELOAD;
          next_cur.st = dcw_pkg::DCW_HOST_HIGH;
        end else begin
          next_cur.cnt = cur.cnt - 8'h01;
        end
      end
      dcw_pkg::DCW_HOST_HIGH: begin
        if (cur.cnt == 8'h00) begin
          next_cur.sclk = 1'b0;
          next_cur.cnt = HALF_RELOAD;
          if (cur.bits == 3'h7) begin
            // Frame stays open until the byte marked last, so commands stay whole
            next_cur.st = cur.last ? dcw_pkg::DCW_HOST_GAP : dcw_pkg::DCW_HOST_IDLE;
          end else begin
            next_cur.bits = cur.bits + 3'h1;
            next_cur.shreg = {cur.shreg[6:0], 1'b0};
            next_cur.din = cur.shreg[6];
            next_cur.st = dcw_pkg::DCW_HOST_LOW;
          end
        end else begin
          next_cur.cnt = cur.cnt - 8'h01;
        end
      end
      dcw_pkg::DCW_HOST_GAP: begin
        if (cur.cnt == 8'h00) begin
          next_cur.cs_n = 1'b1;
          next_cur.st = dcw_pkg::DCW_HOST_IDLE;
        end else begin
          next_cur.cnt = cur.cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur.st <= dcw_pkg::DCW_HOST_IDLE;
      cur.shreg <= 8'h00;
      cur.bits <= 3'h0;
      cur.cnt <= 8'h00;
      cur.last <= 1'b0;
      cur.cs_n <= 1'b1;
      cur.sclk <= 1'b0;
      cur.din <= 1'b0;
      cur.dp_tx <= 1'b0;
      cur.hrdata <= 32'h0;
    end else begin
      cur <= next_cur;
    end
  end

  // Zero-wait slave: every transfer completes OKAY in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur.hrdata;
  assign link.cs_n = cur.cs_n;
  assign link.sclk = cur.sclk;
  assign link.din = cur.din;

endmodule
`default_nettype wire

// file: dcw_monitor.sv
// Concurrent checks on the serial configuration link between host and register bank
`timescale 1ns/1ps
`default_nettype none
module dcw_monitor #(
  parameter int SCLK_HALF = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [7:0] hi_cnt;
  logic [2:0] bit_cnt;
  logic sclk_q;

  // Counters kept here so long widths need no deep repetition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 8'h00;
      bit_cnt <= 3'h0;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
      if (cs_n) begin
        bit_cnt <= 3'h0;
      end else if (sclk && !sclk_q) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_oe_off_deselected: assert property (cs_n |-> !dout_oe)
    else $error("data output driven while deselected");
  a_no_read_drive: assert property (!dout_oe && !dout)
    else $error("data output active without a read");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low outside a frame");
  a_din_hold_high: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("data moved while serial clock high");
  a_din_moves_low: assert property ($changed(din) |-> !sclk)
    else $error("data changed with serial clock high");
  a_sclk_high_width: assert property ($fell(sclk) |-> hi_cnt == 8'(SCLK_HALF))
    else $error("serial clock high phase has wrong width");
  a_frame_byte_whole: assert property ($rose(cs_n) |-> bit_cnt == 3'h0)
    else $error("frame ended inside a byte");
  a_first_edge_soon: assert property ($fell(cs_n) |-> !sclk ##[1:40] $rose(sclk))
    else $error("no serial clock after select");

  c_frame_end: cover property ($rose(cs_n));
  c_byte_done: cover property ($fell(sclk) && bit_cnt == 3'h0);
  c_frame_start: cover property ($fell(cs_n));
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench: AHB host controller driving the DAC register bank
`timescale 1ns/1ps
`default_nettype none
`include "dcw_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_n, agu, gsup, sgr, gsup_r;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, md;
  logic [2:0] hsize, ag;
  logic [7:0] gm, sg, swf, fd, pa, pb;
  logic [23:0] dcg;
  int n_mismatch, n_tests, n_pulse;

  dcw_if link();
  // Short serial clock keeps the run brief; sync needs at least 1 cycle per half period
  dcw_host #(.SCLK_HALF(3)) dcw_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  dcw_device dcw_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link), .reset_powerdown_pin_n(pin_n),
    .gain_mode_ctrl(gm), .sine_digital_gain(sg), .switch_frequency_ctrl(swf), .frequency_divisor(fd),
    .dc_gain(dcg), .pulse_level_first(pa), .pulse_level_second(pb), .analog_gain(ag), .mode(md),
    .analog_gain_used(agu), .gain_supported(gsup), .signal_gen_reset(sgr));
  // Reduced-range bank listens to the same frames on a link of its own
  dcw_if link_r();
  assign link_r.cs_n = link.cs_n;
  assign link_r.sclk = link.sclk;
  assign link_r.din = link.din;
  dcw_device #(.REDUCED_RANGE(1'b1)) dcw_device_reduced_inst (.hclk(hclk), .hresetn(hresetn), .link(link_r),
    .reset_powerdown_pin_n(pin_n), .gain_mode_ctrl(), .sine_digital_gain(), .switch_frequency_ctrl(),
    .frequency_divisor(), .dc_gain(), .pulse_level_first(), .pulse_level_second(), .analog_gain(), .mode(),
    .analog_gain_used(), .gain_supported(gsup_r), .signal_gen_reset());
  dcw_monitor #(.SCLK_HALF(3)) dcw_monitor_inst (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Counted away from the launching edge so each pulse is seen exactly once
  always @(negedge hclk) begin
    if (sgr === 1'b1) n_pulse++;
  end

  task conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task wait_rdy;
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    conclude();
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task idle_wait;
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, 32'(`DCW_OFF_STATUS), 32'h0);
      if (rd[0] === 1'b0) return;
    end
    n_mismatch++;
    conclude();
  endtask

  // Status lags a cycle, so let busy show before polling it
  task frame(input logic [7:0] q[$]);
    foreach (q[i]) begin
      idle_wait();
      ahb(1'b1, 32'(`DCW_OFF_TX), {23'h0, i == q.size() - 1, q[i]});
      repeat (2) @(posedge hclk);
      idle_wait();
      `CHK(rd[1:0], {i != q.size() - 1, 1'b0})
    end
    repeat (8) @(posedge hclk);
  endtask

  task chk_defaults;
    `CHK(gm, {3'h5, 5'h18})
    `CHK(sg, 8'h00)
    `CHK(swf, 8'h00)
    `CHK(fd, `DCW_RST_SINE_RANGE_BIT_DIV)
    `CHK(dcg, 24'h0)
    `CHK({pa, pb}, 16'h0)
    `CHK(ag, 3'h6)
    `CHK(md, 2'h0)
    `CHK({gsup, gsup_r}, 2'b10)
  endtask

  task t_after_reset;
    chk_defaults();
    `CHK(gsup, 1'b1)
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(rd, 32'h0)
    $display("t_after_reset done");
  endtask

  task t_multi;
    frame('{8'h41, 8'h05, 8'h5A, 8'h81, 8'h3C, 8'h11, 8'h22, 8'h33});
    `CHK({sg, swf, fd}, 24'h5A813C)
    `CHK(dcg, 24'h332211)
    `CHK(gm, {3'h5, 5'h18})
    `CHK(pa, 8'h00)
    $display("t_multi done");
  endtask

  task t_modes;
    logic [1:0] m;
    logic [2:0] g;
    int p;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k + 1);
      g = (k == 3) ? 3'h7 : {k[1:0], 1'b0};
      p = n_pulse;
      frame('{8'h40, 8'h00, {3'h7, g, m}});
      `CHK(gm, {3'h5, g, m})
      `CHK({ag, md}, {g, m})
      `CHK(agu, m != 2'h3)
      `CHK(gsup, g != 3'h7)
      `CHK(gsup_r, (g == 3'h0) || (g == 3'h2) || (g == 3'h4))
      `CHK(n_pulse, p + 1)
    end
    $display("t_modes done");
  endtask

  task t_overrun;
    frame('{8'h47, 8'h03, 8'hFF, 8'hE3, 8'h11, 8'h22});
    `CHK({pa, pb}, 16'h1F03)
    `CHK(gm, 8'hBC)
    `CHK(sg, 8'h5A)
    $display("t_overrun done");
  endtask

  task t_abort;
    int p;
    p = n_pulse;
    frame('{8'h40, 8'h00});
    frame('{8'h20, 8'h00, 8'h03});
    `CHK(gm, 8'hBC)
    `CHK(n_pulse, p)
    $display("t_abort done");
  endtask

  task t_reset_cmd;
    logic [7:0] c;
    int p;
    for (int k = 0; k < 2; k++) begin
      c = 8'(6 + k);
      frame('{8'h40, 8'h00, 8'h03});
      p = n_pulse;
      frame('{c});
      chk_defaults();
      `CHK(n_pulse, p + 1)
    end
    $display("t_reset_cmd done");
  endtask

  task t_pin;
    frame('{8'h47, 8'h00, 8'h15});
    `CHK(pa, 8'h15)
    @(posedge hclk) pin_n <= 1'b0;
    repeat (6) @(posedge hclk);
    pin_n <= 1'b1;
    repeat (6) @(posedge hclk);
    chk_defaults();
    $display("t_pin done");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    pin_n = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    n_pulse = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_after_reset();
    t_multi();
    t_modes();
    t_overrun();
    t_abort();
    t_reset_cmd();
    t_pin();
    conclude();
  end
endmodule
`default_nettype wire
